// ==== logic/hsr_defines.vh ====
// shared constants for the high-side relay gate control block
`ifndef HSR_DEFINES_VH
`define HSR_DEFINES_VH
`define HSR_CLK_MHZ 40
`define HSR_OC_DEGLITCH_NS 10000
`define HSR_OV_DEGLITCH_NS 10000
`define HSR_SHORT_DELAY_NS 20000
`define HSR_OV_HOLD_US 1000
`define HSR_OV_BLANK_US 2000
`define HSR_PWM_PERIOD_US 5000
`define HSR_DUTY_MIN 8'h0a
`define HSR_DUTY_MAX 8'h5a
`define HSR_PCT_FULL 8'h64
`define HSR_CNT_W 20
`endif

// ==== logic/hsr_deglitch.v ====
// deglitch counter: output high once input has held high a full count
`timescale 1ns/1ps
`include "hsr_defines.vh"
module hsr_deglitch #(
  parameter [`HSR_CNT_W-1:0] COUNT = 20'h00001
) (
  input wire clk_sys,
  input wire reset_n,
  input wire level_in,
  output reg level_out
);
  reg [`HSR_CNT_W-1:0] cnt_q;
  // restart whenever the qualifying level drops
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= {`HSR_CNT_W{1'b0}};
      level_out <= 1'b0;
    end else if (!level_in) begin
      cnt_q <= {`HSR_CNT_W{1'b0}};
      level_out <= 1'b0;
    end else if (cnt_q < COUNT) begin
      cnt_q <= cnt_q + 20'h00001;
      level_out <= 1'b0;
    end else begin
      level_out <= 1'b1;
    end
  end
endmodule

// ==== logic/hsr_gate_ctrl.v ====
// pump and master relay gate control, fault handling and pump pwm
`timescale 1ns/1ps
`include "hsr_defines.vh"
module hsr_gate_ctrl #(
  parameter [`HSR_CNT_W-1:0] OC_CYC = `HSR_OC_DEGLITCH_NS * `HSR_CLK_MHZ / 1000,
  parameter [`HSR_CNT_W-1:0] OV_CYC = `HSR_OV_DEGLITCH_NS * `HSR_CLK_MHZ / 1000,
  parameter [`HSR_CNT_W-1:0] SHORT_CYC = `HSR_SHORT_DELAY_NS * `HSR_CLK_MHZ / 1000,
  parameter [`HSR_CNT_W-1:0] HOLD_CYC = `HSR_OV_HOLD_US * `HSR_CLK_MHZ,
  parameter [`HSR_CNT_W-1:0] BLANK_CYC = `HSR_OV_BLANK_US * `HSR_CLK_MHZ,
  parameter [`HSR_CNT_W-1:0] PWM_CYC = `HSR_PWM_PERIOD_US * `HSR_CLK_MHZ
) (
  input wire clk_sys,
  input wire reset_n,
  input wire pump_enable_pin,
  input wire master_enable_pin,
  input wire pump_gate_enable_bit,
  input wire master_gate_enable_bit,
  input wire pump_pwm_enable,
  input wire [7:0] pump_pwm_duty,
  input wire pump_drain_sense,
  input wire master_drain_sense,
  input wire pump_gate_short_sense,
  input wire master_gate_short_sense,
  input wire pump_source_sense,
  input wire master_source_sense,
  input wire core_undervoltage,
  input wire battery_undervoltage,
  input wire battery_overvoltage,
  input wire watchdog_fault_in,
  input wire reset_in_n,
  input wire watchdog_action_enable,
  input wire master_overvoltage_action,
  input wire pump_overcurrent_mask,
  input wire pump_gate_short_mask,
  input wire pump_source_short_mask,
  input wire master_overcurrent_mask,
  input wire master_gate_short_mask,
  input wire master_source_short_mask,
  input wire status_read,
  input wire flags_read,
  output reg pump_gate,
  output reg master_gate,
  output reg pump_overcurrent_flag,
  output reg master_overcurrent_flag,
  output reg pump_gate_short_flag,
  output reg master_gate_short_flag,
  output reg pump_source_short_flag,
  output reg master_source_short_flag,
  output reg high_side_summary_fault,
  output reg battery_overvoltage_flag,
  output reg battery_undervoltage_flag,
  output reg power_on_reset_flag,
  output reg external_reset_flag,
  output reg watchdog_status_bit,
  output reg watchdog_fault_bit,
  output reg reset_output_pin_n
);
  ////////////////////////////////////////////////////////////////////////////
  // three-stage synchronisers for all pin and comparator inputs
  localparam NSYNC = 15;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] s1_q;
  reg [NSYNC-1:0] s2_q;
  reg [NSYNC-1:0] s3_q;
  reg [NSYNC-1:0] st_q;
  assign raw_in = {reset_in_n, watchdog_fault_in, battery_overvoltage, battery_undervoltage,
                   core_undervoltage, master_source_sense, pump_source_sense,
                   master_gate_short_sense, pump_gate_short_sense, master_drain_sense,
                   pump_drain_sense, master_enable_pin, pump_enable_pin, 2'b00};
  // a change counts once stages two and three agree
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= {{1'b1}, {(NSYNC-1){1'b0}}};
      s2_q <= {{1'b1}, {(NSYNC-1){1'b0}}};
      s3_q <= {{1'b1}, {(NSYNC-1){1'b0}}};
      st_q <= {{1'b1}, {(NSYNC-1){1'b0}}};
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // take stage two where it agrees with stage three, else hold
      st_q <= (s2_q & ~(s2_q ^ s3_q)) | (st_q & (s2_q ^ s3_q));
    end
  end
  // synchronised levels by source, bits 1:0 are spare
  wire pin_pump = st_q[2]; // floating pin resolved low externally
  wire pin_master = st_q[3];
  wire oc_p_raw = st_q[4];
  wire oc_m_raw = st_q[5];
  wire gs_p_raw = st_q[6];
  wire gs_m_raw = st_q[7];
  wire ss_p_raw = st_q[8];
  wire ss_m_raw = st_q[9];
  wire core_uv = st_q[10];
  wire bat_uv = st_q[11];
  wire bat_ov = st_q[12];
  wire wd_flt = st_q[13];
  wire ext_rst = ~st_q[14];

  ////////////////////////////////////////////////////////////////////////////
  // deglitch counters
  wire oc_p;
  wire oc_m;
  wire ov_det;
  wire gs_p_off;
  wire gs_m_off;
  hsr_deglitch #(.COUNT(OC_CYC)) u_oc_p (.clk_sys(clk_sys), .reset_n(reset_n),
    .level_in(oc_p_raw & pump_gate), .level_out(oc_p));
  hsr_deglitch #(.COUNT(OC_CYC)) u_oc_m (.clk_sys(clk_sys), .reset_n(reset_n),
    .level_in(oc_m_raw & master_gate), .level_out(oc_m));
  hsr_deglitch #(.COUNT(OV_CYC)) u_ov (.clk_sys(clk_sys), .reset_n(reset_n),
    .level_in(bat_ov), .level_out(ov_det));
  hsr_deglitch #(.COUNT(SHORT_CYC)) u_gs_p (.clk_sys(clk_sys), .reset_n(reset_n),
    .level_in(gs_p_raw & ~pump_gate), .level_out(gs_p_off));
  hsr_deglitch #(.COUNT(SHORT_CYC)) u_gs_m (.clk_sys(clk_sys), .reset_n(reset_n),
    .level_in(gs_m_raw & ~master_gate), .level_out(gs_m_off));

  ////////////////////////////////////////////////////////////////////////////
  // enable requests and short-test delay after turn-on
  wire req_pump = pin_pump | pump_gate_enable_bit;
  wire req_master = pin_master | master_gate_enable_bit;
  wire inhibit = core_uv | bat_uv | (wd_flt & watchdog_action_enable);
  reg [`HSR_CNT_W-1:0] on_p_q;
  reg [`HSR_CNT_W-1:0] on_m_q;
  // saturating step of an interval counter
  function [`HSR_CNT_W-1:0] sat_step;
    input [`HSR_CNT_W-1:0] cnt;
    input [`HSR_CNT_W-1:0] lim;
    begin
      sat_step = (cnt < lim) ? cnt + 20'h00001 : cnt;
    end
  endfunction
  // count time since each gate turned on, restart when off
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      on_p_q <= {`HSR_CNT_W{1'b0}};
      on_m_q <= {`HSR_CNT_W{1'b0}};
    end else begin
      on_p_q <= !pump_gate ? {`HSR_CNT_W{1'b0}} : sat_step(on_p_q, SHORT_CYC);
      on_m_q <= !master_gate ? {`HSR_CNT_W{1'b0}} : sat_step(on_m_q, SHORT_CYC);
    end
  end
  // a gate short while on counts only after the short-test delay
  wire gs_p_on = gs_p_raw & pump_gate & (on_p_q >= SHORT_CYC);
  wire gs_m_on = gs_m_raw & master_gate & (on_m_q >= SHORT_CYC);
  wire ss_p = ss_p_raw & pump_gate;
  wire ss_m = ss_m_raw & master_gate;

  ////////////////////////////////////////////////////////////////////////////
  // fault latches: gate stays off until the request is taken away
  reg lock_p_q;
  reg lock_m_q;
  // trip terms per gate, a set mask bit keeps the gate on
  wire trip_p = (oc_p & ~pump_overcurrent_mask) | (gs_p_on & ~pump_gate_short_mask)
    | (ss_p & ~pump_source_short_mask) | (gs_p_off & ~pump_gate_short_mask);
  wire trip_m = (oc_m & ~master_overcurrent_mask) | (gs_m_on & ~master_gate_short_mask)
    | (ss_m & ~master_source_short_mask) | (gs_m_off & ~master_gate_short_mask);
  // release once the fault is gone and the request is taken away
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lock_p_q <= 1'b0;
      lock_m_q <= 1'b0;
    end else begin
      lock_p_q <= trip_p | (lock_p_q & req_pump);
      lock_m_q <= trip_m | (lock_m_q & req_master);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overvoltage sequence: active, hold, blanking
  localparam [3:0] OV_IDLE = 4'b0001;
  localparam [3:0] OV_ACT = 4'b0010;
  localparam [3:0] OV_HOLD = 4'b0100;
  localparam [3:0] OV_BLANK = 4'b1000;
  reg [3:0] ov_st_q;
  reg [`HSR_CNT_W-1:0] ov_cnt_q;
  reg ov_seen_q;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ov_st_q <= OV_IDLE;
      ov_cnt_q <= {`HSR_CNT_W{1'b0}};
    end else begin
      case (ov_st_q)
        OV_IDLE: begin
          ov_cnt_q <= {`HSR_CNT_W{1'b0}};
          if (ov_det && !ov_seen_q) ov_st_q <= OV_ACT;
        end
        OV_ACT: begin
          ov_cnt_q <= {`HSR_CNT_W{1'b0}};
          if (!bat_ov) ov_st_q <= OV_HOLD;
        end
        OV_HOLD: begin
          if (ov_cnt_q >= HOLD_CYC) begin
            ov_st_q <= OV_BLANK;
            ov_cnt_q <= {`HSR_CNT_W{1'b0}};
          end else begin
            ov_cnt_q <= ov_cnt_q + 20'h00001;
          end
        end
        OV_BLANK: begin
          if (ov_cnt_q >= BLANK_CYC) ov_st_q <= OV_IDLE;
          else ov_cnt_q <= ov_cnt_q + 20'h00001;
        end
        default: ov_st_q <= OV_IDLE;
      endcase
    end
  end
  // pump forced through active and hold, master acts while active
  wire ov_force = ov_st_q[1] | ov_st_q[2];
  wire ov_active = ov_det | ov_st_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // pump pwm, duty clamped to 10..90 percent
  reg [`HSR_CNT_W-1:0] pwm_cnt_q;
  wire [7:0] duty = pump_pwm_duty < `HSR_DUTY_MIN ? `HSR_DUTY_MIN :
                    (pump_pwm_duty > `HSR_DUTY_MAX ? `HSR_DUTY_MAX : pump_pwm_duty);
  // on length in clock cycles for the clamped duty
  wire [27:0] on_len = PWM_CYC * duty / `HSR_PCT_FULL;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) pwm_cnt_q <= {`HSR_CNT_W{1'b0}};
    else if (!pump_pwm_enable || pwm_cnt_q >= PWM_CYC - 20'h00001) pwm_cnt_q <= {`HSR_CNT_W{1'b0}};
    else pwm_cnt_q <= pwm_cnt_q + 20'h00001;
  end
  wire pwm_on = !pump_pwm_enable || ({8'h00, pwm_cnt_q} < on_len);

  ////////////////////////////////////////////////////////////////////////////
  // gate outputs
  reg master_prev_q;
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pump_gate <= 1'b0;
      master_gate <= 1'b0;
      master_prev_q <= 1'b0;
    end else begin
      if (ov_force) pump_gate <= 1'b1;
      else pump_gate <= req_pump & pwm_on & ~inhibit & ~ext_rst & ~lock_p_q & ~trip_p
        & ~battery_overvoltage_flag;
      if (!ov_active) master_prev_q <= master_gate;
      if (ov_active) master_gate <= master_overvoltage_action ? 1'b0 :
        master_prev_q & ~inhibit & ~ext_rst & ~lock_m_q & ~trip_m;
      else master_gate <= req_master & ~inhibit & ~ext_rst & ~lock_m_q & ~trip_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky status flags, set wins over read clear
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pump_overcurrent_flag <= 1'b0;
      master_overcurrent_flag <= 1'b0;
      pump_gate_short_flag <= 1'b0;
      master_gate_short_flag <= 1'b0;
      pump_source_short_flag <= 1'b0;
      master_source_short_flag <= 1'b0;
      high_side_summary_fault <= 1'b0;
      battery_overvoltage_flag <= 1'b0;
      battery_undervoltage_flag <= 1'b0;
      power_on_reset_flag <= 1'b0;
      external_reset_flag <= 1'b0;
      watchdog_status_bit <= 1'b1;
      watchdog_fault_bit <= 1'b0;
      reset_output_pin_n <= 1'b0;
      ov_seen_q <= 1'b0;
    end else begin
      pump_overcurrent_flag <= oc_p | (pump_overcurrent_flag & ~flags_read);
      master_overcurrent_flag <= oc_m | (master_overcurrent_flag & ~flags_read);
      pump_gate_short_flag <= (gs_p_on | (gs_p_off & req_pump)) | (pump_gate_short_flag & ~flags_read);
      master_gate_short_flag <= (gs_m_on | (gs_m_off & req_master)) | (master_gate_short_flag & ~flags_read);
      pump_source_short_flag <= ss_p | (pump_source_short_flag & ~flags_read);
      master_source_short_flag <= ss_m | (master_source_short_flag & ~flags_read);
      high_side_summary_fault <= oc_p | oc_m | gs_p_on | gs_m_on | ss_p | ss_m | (gs_p_off & req_pump)
        | (gs_m_off & req_master) | (high_side_summary_fault & ~flags_read);
      battery_overvoltage_flag <= ov_det | (battery_overvoltage_flag & ~(status_read & ~bat_ov));
      battery_undervoltage_flag <= bat_uv | (battery_undervoltage_flag & ~status_read);
      power_on_reset_flag <= core_uv | (power_on_reset_flag & ~status_read);
      external_reset_flag <= ext_rst | (external_reset_flag & ~status_read);
      watchdog_fault_bit <= (wd_flt & watchdog_action_enable) | (watchdog_fault_bit & ~status_read);
      watchdog_status_bit <= ~(wd_flt & watchdog_action_enable);
      reset_output_pin_n <= ~core_uv;
      ov_seen_q <= (ov_st_q != OV_IDLE) ? 1'b1 : (ov_seen_q & ov_det);
    end
  end
endmodule

// ==== verification/hsr_gate_ctrl_properties.sv ====
// port checker for the relay gate control block
`timescale 1ns/1ps
module hsr_gate_chk (
  input wire clk_sys,
  input wire reset_n,
  input wire reset_in_n,
  input wire core_undervoltage,
  input wire battery_undervoltage,
  input wire battery_overvoltage,
  input wire watchdog_fault_in,
  input wire watchdog_action_enable,
  input wire master_overvoltage_action,
  input wire flags_read,
  input wire pump_gate,
  input wire master_gate,
  input wire pump_overcurrent_flag,
  input wire high_side_summary_fault,
  input wire battery_overvoltage_flag,
  input wire battery_undervoltage_flag,
  input wire power_on_reset_flag,
  input wire external_reset_flag,
  input wire watchdog_status_bit,
  input wire watchdog_fault_bit,
  input wire reset_output_pin_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // supply and reset interlocks
  por_drop_a: assert property (core_undervoltage [*8] |-> !pump_gate && !reset_output_pin_n
    && power_on_reset_flag) else $error("core undervoltage not handled");
  ext_reset_a: assert property (!reset_in_n [*8] |-> !pump_gate && external_reset_flag)
    else $error("external reset not handled");
  uv_block_a: assert property (battery_undervoltage [*8] |-> !master_gate && battery_undervoltage_flag)
    else $error("battery undervoltage not handled");
  wd_block_a: assert property ((watchdog_fault_in && watchdog_action_enable) [*8] |-> !pump_gate
    && watchdog_fault_bit && !watchdog_status_bit) else $error("watchdog fault not handled");
  // high-side fault flags
  oc_sticky_a: assert property (pump_overcurrent_flag && !flags_read |=> pump_overcurrent_flag)
    else $error("overcurrent flag lost");
  summary_set_a: assert property ($rose(pump_overcurrent_flag) |-> ##[0:1] high_side_summary_fault)
    else $error("summary fault missing");
  // overvoltage behaviour
  ov_flag_a: assert property (battery_overvoltage [*8] ##1 battery_overvoltage [*7] |-> battery_overvoltage_flag)
    else $error("overvoltage flag missing");
  ov_pump_a: assert property ($rose(battery_overvoltage_flag) |-> ##[0:2] pump_gate)
    else $error("pump gate not forced on");
  ov_master_a: assert property ($rose(battery_overvoltage_flag) && master_overvoltage_action |-> !master_gate)
    else $error("master gate not dropped");
endmodule
bind hsr_gate_ctrl hsr_gate_chk u_chk (.*);

// ==== verification/hsr_fet_model.sv ====
// external mosfet pair producing the comparator senses
`timescale 1ns/1ps
module hsr_fet_model (
  input wire pump_gate,
  input wire master_gate,
  input wire [2:0] pump_fault,
  input wire [2:0] master_fault,
  output wire pump_drain_sense,
  output wire master_drain_sense,
  output wire pump_gate_short_sense,
  output wire master_gate_short_sense,
  output wire pump_source_sense,
  output wire master_source_sense
);
  // overcurrent and source short only show while the fet conducts
  assign pump_drain_sense = pump_gate & pump_fault[0];
  assign master_drain_sense = master_gate & master_fault[0];
  assign pump_source_sense = pump_gate & pump_fault[2];
  assign master_source_sense = master_gate & master_fault[2];
  // a shorted gate reads low whatever the driver does
  assign pump_gate_short_sense = pump_fault[1];
  assign master_gate_short_sense = master_fault[1];
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the relay gate control block
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic pump_enable_pin, master_enable_pin, pump_gate_enable_bit, master_gate_enable_bit, pump_pwm_enable;
  logic core_undervoltage, battery_undervoltage, battery_overvoltage, watchdog_fault_in, reset_in_n;
  logic watchdog_action_enable, master_overvoltage_action, pump_overcurrent_mask, pump_gate_short_mask;
  logic pump_source_short_mask, master_overcurrent_mask, master_gate_short_mask, master_source_short_mask;
  logic status_read, flags_read;
  logic [7:0] pump_pwm_duty;
  logic [2:0] pump_fault, master_fault;
  wire pump_drain_sense, master_drain_sense, pump_gate_short_sense, master_gate_short_sense;
  wire pump_source_sense, master_source_sense, pump_gate, master_gate, pump_overcurrent_flag;
  wire master_overcurrent_flag, pump_gate_short_flag, master_gate_short_flag, pump_source_short_flag;
  wire master_source_short_flag, high_side_summary_fault, battery_overvoltage_flag, battery_undervoltage_flag;
  wire power_on_reset_flag, external_reset_flag, watchdog_status_bit, watchdog_fault_bit, reset_output_pin_n;
  int error_cnt = 0;
  int tests_run = 0;
  int hi;
  logic [6:0] lock_exp [4] = '{7'h11, 7'h32, 7'h24, 7'h38};
  logic [7:0] duty_in [3] = '{8'h05, 8'h32, 8'h5f};
  logic [7:0] duty_exp [3] = '{8'h0a, 8'h32, 8'h5a};
  ////////////////////////////////////////
  // clock, design and far side
  always #12.5 clk_sys = ~clk_sys;
  hsr_gate_ctrl #(.OC_CYC(20'h00004), .OV_CYC(20'h00004), .SHORT_CYC(20'h00008), .HOLD_CYC(20'h00014),
    .BLANK_CYC(20'h00014), .PWM_CYC(20'h00064)) DUT (.*);
  hsr_fet_model u_fet (.*);
  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_pulse();
    status_read = 1'b1;
    flags_read = 1'b1;
    cyc(1);
    status_read = 1'b0;
    flags_read = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // pump fault k with all masks m, then release and re-enable
  task automatic hs_fault(input int k, input logic m);
    {pump_source_short_mask, pump_gate_short_mask, pump_overcurrent_mask} = {3{m}};
    pump_gate_enable_bit = 1'b1;
    cyc(20);
    pump_fault[k] = 1'b1;
    cyc(24);
    chk("pump gate", pump_gate, m);
    chk("hs flags", {high_side_summary_fault, pump_source_short_flag, pump_gate_short_flag,
      pump_overcurrent_flag}, 16'h0008 | (16'h0001 << k));
    pump_fault[k] = 1'b0;
    pump_gate_enable_bit = 1'b0;
    cyc(8);
    rd_pulse();
    pump_gate_enable_bit = 1'b1;
    cyc(10);
    chk("re-enabled gate", {high_side_summary_fault, pump_gate}, 16'h0001);
    pump_gate_enable_bit = 1'b0;
    cyc(10);
  endtask
  ////////////////////////////////////////
  // hang guard
  initial begin
    #2000000;
    error_cnt++;
    finish_test();
  end
  // main sequence
  initial begin
    {pump_enable_pin, master_enable_pin, pump_gate_enable_bit, master_gate_enable_bit, pump_pwm_enable} = '0;
    {core_undervoltage, battery_undervoltage, battery_overvoltage, watchdog_fault_in, watchdog_action_enable} = '0;
    {master_overvoltage_action, pump_overcurrent_mask, pump_gate_short_mask, pump_source_short_mask} = '0;
    {master_overcurrent_mask, master_gate_short_mask, master_source_short_mask, status_read, flags_read} = '0;
    {pump_fault, master_fault} = '0;
    reset_in_n = 1'b1;
    pump_pwm_duty = 8'h32;
    cyc(3);
    chk("reset outputs", {pump_gate, master_gate, pump_overcurrent_flag, master_overcurrent_flag,
      pump_gate_short_flag, master_gate_short_flag, pump_source_short_flag, master_source_short_flag,
      high_side_summary_fault, battery_overvoltage_flag, battery_undervoltage_flag, power_on_reset_flag,
      external_reset_flag, watchdog_fault_bit, watchdog_status_bit, reset_output_pin_n}, 16'h0002);
    cyc(3);
    reset_n = 1'b1;
    cyc(2);
    chk("reset pin", reset_output_pin_n, 1'b1);
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      {pump_enable_pin, pump_gate_enable_bit} = k[1:0];
      {master_gate_enable_bit, master_enable_pin} = k[1:0];
      cyc(8);
      chk("pump gate", pump_gate, |k[1:0]);
      chk("master gate", master_gate, |k[1:0]);
    end
    {pump_enable_pin, pump_gate_enable_bit, master_gate_enable_bit, master_enable_pin} = '0;
    cyc(8);
    $display("test enables done");
    for (int k = 0; k < 3; k++) begin
      hs_fault(k, 1'b0);
      hs_fault(k, 1'b1);
    end
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 2; m++) begin
        {master_source_short_mask, master_gate_short_mask, master_overcurrent_mask} = {3{m[0]}};
        master_gate_enable_bit = 1'b1;
        cyc(20);
        master_fault[k] = 1'b1;
        cyc(24);
        chk("master gate", master_gate, m[0]);
        chk("master flags", {high_side_summary_fault, master_source_short_flag, master_gate_short_flag,
          master_overcurrent_flag}, 16'h0008 | (16'h0001 << k));
        master_fault[k] = 1'b0;
        master_gate_enable_bit = 1'b0;
        cyc(8);
        rd_pulse();
      end
    end
    $display("test faults done");
    for (int m = 0; m < 2; m++) begin
      pump_gate_short_mask = m[0];
      pump_fault[1] = 1'b1;
      cyc(24);
      pump_gate_enable_bit = 1'b1;
      cyc(12);
      chk("short while off", {pump_gate_short_flag, pump_gate}, {15'h0001, m[0]});
      pump_fault[1] = 1'b0;
      pump_gate_enable_bit = 1'b0;
      cyc(8);
      rd_pulse();
    end
    $display("test gate short done");
    watchdog_action_enable = 1'b1;
    for (int k = 0; k < 4; k++) begin
      {pump_gate_enable_bit, master_gate_enable_bit} = 2'h3;
      cyc(10);
      {reset_in_n, watchdog_fault_in, battery_undervoltage, core_undervoltage} = 4'h8 ^ (4'h1 << k);
      cyc(12);
      chk("pump gate", pump_gate, 1'b0);
      chk("lock state", {master_gate, reset_output_pin_n, watchdog_status_bit, external_reset_flag,
        watchdog_fault_bit, battery_undervoltage_flag, power_on_reset_flag}, lock_exp[k]);
      {reset_in_n, watchdog_fault_in, battery_undervoltage, core_undervoltage} = 4'h8;
      {pump_gate_enable_bit, master_gate_enable_bit} = 2'h0;
      cyc(12);
      rd_pulse();
    end
    $display("test interlocks done");
    {master_overvoltage_action, master_gate_enable_bit} = 2'h3;
    cyc(10);
    battery_overvoltage = 1'b1;
    cyc(16);
    chk("ov gates", {pump_gate, master_gate, battery_overvoltage_flag}, 16'h0005);
    battery_overvoltage = 1'b0;
    cyc(12);
    chk("ov hold", pump_gate, 1'b1);
    cyc(20);
    chk("ov release", pump_gate, 1'b0);
    battery_overvoltage = 1'b1;
    cyc(10);
    chk("ov blanked", pump_gate, 1'b0);
    battery_overvoltage = 1'b0;
    cyc(30);
    chk("ov flag kept", battery_overvoltage_flag, 1'b1);
    rd_pulse();
    chk("ov flag read", battery_overvoltage_flag, 1'b0);
    {master_overvoltage_action, master_gate_enable_bit} = 2'h0;
    $display("test overvoltage done");
    pump_pwm_enable = 1'b1;
    pump_gate_enable_bit = 1'b1;
    for (int k = 0; k < 3; k++) begin
      pump_pwm_duty = duty_in[k];
      cyc(200);
      hi = 0;
      repeat (100) begin
        cyc(1);
        hi += (pump_gate === 1'b1);
      end
      chk("pwm on cycles", hi[15:0], {8'h00, duty_exp[k]});
    end
    $display("test pwm done");
    finish_test();
  end
endmodule
